// ---- design/crtc_pkg.sv ----
// constants, register map and types of the calendar real-time clock
package crtc_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] CRTC_OFS_CTRL = 8'h00;
    localparam logic [7:0] CRTC_OFS_PRESC = 8'h04;
    localparam logic [7:0] CRTC_OFS_TIME = 8'h08;
    localparam logic [7:0] CRTC_OFS_DATE = 8'h0C;
    localparam logic [7:0] CRTC_OFS_ALARM = 8'h10;
    localparam logic [7:0] CRTC_OFS_PERIOD = 8'h14;
    localparam logic [7:0] CRTC_OFS_STATUS = 8'h18;
    localparam logic [7:0] CRTC_OFS_MASK = 8'h1C;
    localparam logic [7:0] CRTC_OFS_WAKE = 8'h20;

    // control register fields
    localparam int CRTC_CTRL_EN_BIT = 0;
    localparam int CRTC_CTRL_SEL_LSB = 1;
    localparam int CRTC_CTRL_CAL_BIT = 3;
    localparam logic [3:0] CRTC_CTRL_RST = 4'h0;

    // drive clock source encodings
    localparam logic [1:0] CRTC_SEL_SLOW = 2'h0;
    localparam logic [1:0] CRTC_SEL_FAST_INT = 2'h1;
    localparam logic [1:0] CRTC_SEL_FAST_EXT = 2'h2;

    // fast oscillators are divided by 128
    localparam int CRTC_DIV_W = 7;
    localparam logic [6:0] CRTC_DIV_LAST = 7'h7F;

    // one-second prescaler, reload value for a 32768 Hz drive
    localparam int CRTC_PRESC_W = 22;
    localparam logic [21:0] CRTC_PRESC_RST = 22'h007FFF;
    // counter bit that toggles at 256 Hz with the default reload
    localparam int CRTC_CAL_BIT = 6;

    // periodic interval: reload + 1 drive cycles, never below 2
    localparam int CRTC_PER_W = 16;
    localparam logic [15:0] CRTC_PER_MIN = 16'h0001;
    localparam logic [15:0] CRTC_PER_RST = 16'h0001;

    // event bits of status, mask and wake enable
    localparam int CRTC_EV_N = 3;
    localparam int CRTC_EV_ALARM = 0;
    localparam int CRTC_EV_PERIOD = 1;
    localparam int CRTC_EV_SECOND = 2;

    // time word field positions (also used by the alarm word)
    localparam int CRTC_F_SEC = 0;
    localparam int CRTC_F_MIN = 8;
    localparam int CRTC_F_HOUR = 16;
    localparam int CRTC_F_WDAY = 24;
    localparam int CRTC_F_ADATE = 24;
    // date word field positions
    localparam int CRTC_F_DATE = 0;
    localparam int CRTC_F_MONTH = 8;
    localparam int CRTC_F_YEAR = 16;

    // calendar limits and reset values
    localparam logic [5:0] CRTC_SEC_LAST = 6'h3B;
    localparam logic [5:0] CRTC_MIN_LAST = 6'h3B;
    localparam logic [4:0] CRTC_HOUR_LAST = 5'h17;
    localparam logic [2:0] CRTC_WDAY_LAST = 3'h7;
    localparam logic [3:0] CRTC_MONTH_LAST = 4'hC;
    localparam logic [6:0] CRTC_YEAR_LAST = 7'h63;
    localparam logic [2:0] CRTC_WDAY_RST = 3'h1;
    localparam logic [4:0] CRTC_DATE_RST = 5'h01;
    localparam logic [3:0] CRTC_MONTH_RST = 4'h1;

    // running calendar time, binary fields
    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] date;
        logic [2:0] wday;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } crtc_time_t;

    // alarm compare fields
    typedef struct packed {
        logic [4:0] date;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } crtc_alarm_t;

endpackage

// ---- design/crtc_calendar.sv ----
// calendar counters: seconds to year with month lengths and leap years
`timescale 1ns/1ps
module crtc_calendar
    import crtc_pkg::*;
(
    // clock and always-on reset
    input wire logic pclk,
    input wire logic por_n,
    // advance and load controls
    input wire logic sec_tick,
    input wire logic load_time,
    input wire logic load_date,
    input wire logic [31:0] wdata,
    // current calendar
    output crtc_time_t now
);

    logic [4:0] month_len;
    logic leap;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic date_wrap;
    logic month_wrap;
    crtc_time_t next_now;

    // years 00..99 of one century, so every fourth is a leap year
    assign leap = (now.year[1:0] == 2'h0);
    assign month_len = (now.month == 4'h2) ? (leap ? 5'h1D : 5'h1C) :
        ((now.month == 4'h4) || (now.month == 4'h6) || (now.month == 4'h9) || (now.month == 4'hB)) ? 5'h1E :
        5'h1F;

    // carry chain
    assign sec_wrap = sec_tick && (now.sec == CRTC_SEC_LAST);
    assign min_wrap = sec_wrap && (now.min == CRTC_MIN_LAST);
    assign hour_wrap = min_wrap && (now.hour == CRTC_HOUR_LAST);
    assign date_wrap = hour_wrap && (now.date >= month_len);
    assign month_wrap = date_wrap && (now.month == CRTC_MONTH_LAST);

    // next value: software load first, then the one-second advance
    always_comb begin
        next_now = now;
        if (load_time) begin
            next_now.sec = wdata[CRTC_F_SEC +: 6];
            next_now.min = wdata[CRTC_F_MIN +: 6];
            next_now.hour = wdata[CRTC_F_HOUR +: 5];
            next_now.wday = wdata[CRTC_F_WDAY +: 3];
        end else if (sec_tick) begin
            next_now.sec = sec_wrap ? 6'h00 : now.sec + 6'h01;
            if (sec_wrap) begin
                next_now.min = min_wrap ? 6'h00 : now.min + 6'h01;
            end
            if (min_wrap) begin
                next_now.hour = hour_wrap ? 5'h00 : now.hour + 5'h01;
            end
            if (hour_wrap) begin
                next_now.wday = (now.wday == CRTC_WDAY_LAST) ? CRTC_WDAY_RST : now.wday + 3'h1;
            end
        end
        if (load_date) begin
            next_now.date = wdata[CRTC_F_DATE +: 5];
            next_now.month = wdata[CRTC_F_MONTH +: 4];
            next_now.year = wdata[CRTC_F_YEAR +: 7];
        end else if (hour_wrap && !load_time) begin
            next_now.date = date_wrap ? CRTC_DATE_RST : now.date + 5'h01;
            if (date_wrap) begin
                next_now.month = month_wrap ? CRTC_MONTH_RST : now.month + 4'h1;
            end
            if (month_wrap) begin
                next_now.year = (now.year == CRTC_YEAR_LAST) ? 7'h00 : now.year + 7'h01;
            end
        end
    end

    // only power-on clears the calendar
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            now <= '{year: 7'h00, month: CRTC_MONTH_RST, date: CRTC_DATE_RST, wday: CRTC_WDAY_RST,
                     hour: 5'h00, min: 6'h00, sec: 6'h00};
        end else begin
            now <= next_now;
        end
    end

endmodule

// ---- design/crtc_core.sv ----
// calendar real-time clock core with apb registers, alarm and periodic events
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps

// What this block does
// - calendar counters run without software help
// - alarm event when time matches alarm
// - periodic event, interval at least two cycles
// - system reset leaves clock state untouched
// - low-power entry and wake keep state
// - drive clock from three selectable sources
// - 256 Hz calibration output from time base at the default reload
// - 22-bit prescaler makes the one-second tick
// - wake-up request on enabled events
module crtc_core
    import crtc_pkg::*;
(
    // apb clock and bus reset
    input wire logic pclk,
    input wire logic presetn,
    // always-on power-on reset of the clock state
    input wire logic por_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator levels, synchronous to pclk
    input wire logic slow_internal_rc_osc,
    input wire logic fast_internal_rc_osc,
    input wire logic fast_external_osc,
    // outputs to the system
    output logic irq,
    output logic wakeup,
    output logic cal_out
);

    // control and configuration
    logic enable;
    logic [1:0] clk_sel;
    logic cal_en;
    logic [CRTC_PRESC_W-1:0] presc_reload;
    logic [CRTC_PRESC_W-1:0] presc_cnt;
    logic [CRTC_PER_W-1:0] period_reload;
    logic [CRTC_PER_W-1:0] period_cnt;
    crtc_alarm_t alarm;
    logic [CRTC_EV_N-1:0] status;
    logic [CRTC_EV_N-1:0] mask;
    logic [CRTC_EV_N-1:0] wake_en;
    crtc_time_t now;

    // oscillator edge detection and dividers
    logic slow_prev;
    logic slow_tick;
    logic [1:0] fast_in;
    logic [1:0] fast_tick;
    logic drive_tick;

    // time base
    logic sec_tick;
    logic alarm_chk;
    logic alarm_hit;
    logic alarm_match;
    logic period_hit;
    logic [CRTC_EV_N-1:0] ev_set;
    logic [CRTC_EV_N-1:0] ev_clr;
    logic cal_src;

    // bus decode
    logic setup_ok;
    logic fire;
    logic wr_fire;
    logic rd_fire;
    logic sel_ctrl;
    logic sel_presc;
    logic sel_time;
    logic sel_date;
    logic sel_alarm;
    logic sel_period;
    logic sel_status;
    logic sel_mask;
    logic sel_wake;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [CRTC_PER_W-1:0] period_wr;
    logic load_time;
    logic load_date;
    logic presc_load;
    logic period_load;
    logic status_rd;
    logic rd_capture;

    // bus transfer phases: one wait state, then the answer
    assign setup_ok = psel && penable && !pready;
    assign fire = psel && penable && pready;
    assign wr_fire = fire && pwrite;
    assign rd_fire = fire && !pwrite;

    // write strobes of the loadable counters, one named source per load
    assign load_time = wr_fire && sel_time;
    assign load_date = wr_fire && sel_date;
    assign presc_load = wr_fire && sel_presc;
    assign period_load = wr_fire && sel_period;
    // status clears on the completing edge only, never in the wait state
    assign status_rd = rd_fire && sel_status;
    // read data captured for reads only, so a write leaves the last read word standing
    assign rd_capture = setup_ok && !pwrite;

    // address decode
    assign sel_ctrl = (paddr == CRTC_OFS_CTRL);
    assign sel_presc = (paddr == CRTC_OFS_PRESC);
    assign sel_time = (paddr == CRTC_OFS_TIME);
    assign sel_date = (paddr == CRTC_OFS_DATE);
    assign sel_alarm = (paddr == CRTC_OFS_ALARM);
    assign sel_period = (paddr == CRTC_OFS_PERIOD);
    assign sel_status = (paddr == CRTC_OFS_STATUS);
    assign sel_mask = (paddr == CRTC_OFS_MASK);
    assign sel_wake = (paddr == CRTC_OFS_WAKE);
    assign addr_ok = sel_ctrl | sel_presc | sel_time | sel_date | sel_alarm | sel_period |
                     sel_status | sel_mask | sel_wake;

    // read data selection, unmapped and reserved bits read zero
    assign rd_mux = sel_ctrl ? {28'h0000000, cal_en, clk_sel, enable} :
        sel_presc ? {10'h000, presc_reload} :
        sel_time ? {5'h00, now.wday, 3'h0, now.hour, 2'h0, now.min, 2'h0, now.sec} :
        sel_date ? {9'h000, now.year, 4'h0, now.month, 3'h0, now.date} :
        sel_alarm ? {3'h0, alarm.date, 3'h0, alarm.hour, 2'h0, alarm.min, 2'h0, alarm.sec} :
        sel_period ? {16'h0000, period_reload} :
        sel_status ? {29'h00000000, status} :
        sel_mask ? {29'h00000000, mask} :
        sel_wake ? {29'h00000000, wake_en} :
        32'h00000000;

    // periodic reload clamped so the interval never drops below two cycles
    assign period_wr = (pwdata[CRTC_PER_W-1:0] < CRTC_PER_MIN) ? CRTC_PER_MIN : pwdata[CRTC_PER_W-1:0];

    // bus answer flops, cleared by the system reset only
    // pready is a flop, so every transfer gets exactly one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ok;
            prdata <= rd_capture ? rd_mux : prdata;
            pslverr <= setup_ok && !addr_ok;
        end
    end

    // configuration lives on the power-on reset, so a system reset keeps it
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            enable <= CRTC_CTRL_RST[CRTC_CTRL_EN_BIT];
            clk_sel <= CRTC_CTRL_RST[CRTC_CTRL_SEL_LSB +: 2];
            cal_en <= CRTC_CTRL_RST[CRTC_CTRL_CAL_BIT];
            presc_reload <= CRTC_PRESC_RST;
            period_reload <= CRTC_PER_RST;
            alarm <= '0;
            mask <= '0;
            wake_en <= '0;
        end else if (wr_fire) begin
            if (sel_ctrl) begin
                enable <= pwdata[CRTC_CTRL_EN_BIT];
                clk_sel <= pwdata[CRTC_CTRL_SEL_LSB +: 2];
                cal_en <= pwdata[CRTC_CTRL_CAL_BIT];
            end
            if (sel_presc) begin
                presc_reload <= pwdata[CRTC_PRESC_W-1:0];
            end
            if (sel_period) begin
                period_reload <= period_wr;
            end
            if (sel_alarm) begin
                alarm <= '{date: pwdata[CRTC_F_ADATE +: 5], hour: pwdata[CRTC_F_HOUR +: 5],
                           min: pwdata[CRTC_F_MIN +: 6], sec: pwdata[CRTC_F_SEC +: 6]};
            end
            if (sel_mask) begin
                mask <= pwdata[CRTC_EV_N-1:0];
            end
            if (sel_wake) begin
                wake_en <= pwdata[CRTC_EV_N-1:0];
            end
        end
    end

    // slow oscillator: one drive cycle per rising edge
    // a source already high at power-on gives one early tick
    assign slow_tick = slow_internal_rc_osc && !slow_prev;

    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            slow_prev <= 1'b0;
        end else begin
            slow_prev <= slow_internal_rc_osc;
        end
    end

    // fast oscillators, each divided by 128 in its own counter
    assign fast_in = {fast_external_osc, fast_internal_rc_osc};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_fast_div
            logic prev;
            logic [CRTC_DIV_W-1:0] cnt;
            logic edge_seen;

            assign edge_seen = fast_in[i] && !prev;
            assign fast_tick[i] = edge_seen && (cnt == CRTC_DIV_LAST);

            // free-running so switching sources costs no resync
            always_ff @(posedge pclk or negedge por_n) begin
                if (!por_n) begin
                    prev <= 1'b0;
                    cnt <= '0;
                end else begin
                    prev <= fast_in[i];
                    cnt <= edge_seen ? cnt + 7'h01 : cnt;
                end
            end
        end
    endgenerate

    // drive clock selection; the unused code falls back to the slow source
    // enable low freezes prescaler, period count and calendar alike
    assign drive_tick = enable && ((clk_sel == CRTC_SEL_FAST_INT) ? fast_tick[0] :
                                   (clk_sel == CRTC_SEL_FAST_EXT) ? fast_tick[1] :
                                   slow_tick);

    // one-second tick when the prescaler passes zero
    // one second is reload + 1 drive cycles
    assign sec_tick = drive_tick && (presc_cnt == '0);

    // prescaler and periodic counters count drive cycles
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            presc_cnt <= CRTC_PRESC_RST;
            period_cnt <= CRTC_PER_RST;
        end else begin
            if (presc_load) begin
                presc_cnt <= pwdata[CRTC_PRESC_W-1:0];
            end else if (drive_tick) begin
                presc_cnt <= (presc_cnt == '0) ? presc_reload : presc_cnt - 22'h000001;
            end
            if (period_load) begin
                period_cnt <= period_wr;
            end else if (drive_tick) begin
                period_cnt <= (period_cnt == '0) ? period_reload : period_cnt - 16'h0001;
            end
        end
    end

    // periodic event on every pass through zero
    // a period write reloads the counter, so the first interval is full
    assign period_hit = drive_tick && (period_cnt == '0);

    // calendar advances on the one-second tick
    // time and date words load on separate writes, never together
    crtc_calendar u_calendar (
        .pclk(pclk),
        .por_n(por_n),
        .sec_tick(sec_tick),
        .load_time(load_time),
        .load_date(load_date),
        .wdata(pwdata),
        .now(now)
    );

    // alarm compare one cycle after the update, so it sees the new time
    assign alarm_match = (now.sec == alarm.sec) && (now.min == alarm.min) &&
                         (now.hour == alarm.hour) && (now.date == alarm.date);
    assign alarm_hit = alarm_chk && alarm_match;

    // event set and read-clear vectors
    assign ev_set = {sec_tick, period_hit, alarm_hit};
    assign ev_clr = status_rd ? status : '0;

    // sticky status; an event in the clearing cycle survives the clear
    // masks gate only the outputs, so status records every event
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            alarm_chk <= 1'b0;
            status <= '0;
        end else begin
            alarm_chk <= sec_tick;
            status <= (status & ~ev_clr) | ev_set;
        end
    end

    // calibration level from the prescaler; only the default reload gives 256 Hz
    assign cal_src = cal_en && enable && presc_cnt[CRTC_CAL_BIT];

    // system outputs, registered; nothing here reacts to low-power entry
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            irq <= 1'b0;
            wakeup <= 1'b0;
            cal_out <= 1'b0;
        end else begin
            irq <= |(status & mask);
            wakeup <= |(status & wake_en);
            cal_out <= cal_src;
        end
    end

endmodule

// ---- testbench/crtc_core_properties.sv ----
// checker of the rtc core ports: apb answers and event outputs
`timescale 1ns/1ps
module crtc_props
    import crtc_pkg::*;
(
    // clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // outputs to the system
    input wire logic irq,
    input wire logic wakeup,
    input wire logic cal_out
);
    default clocking cb @(posedge pclk);
    endclocking
    // system reset forces the bus outputs low and power-on reset the event outputs, so nothing is judged then
    default disable iff (!presetn || !por_n);

    // setup cycle, then one wait state and a single-cycle answer
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        !pready ##1 pready ##1 !pready;
    endsequence
    // completed write to one address with a condition on its data
    sequence wr_s(logic [7:0] a, logic z);
        psel && penable && pready && pwrite && paddr == a && z;
    endsequence

    answer_delay_a: assert property (setup_s |=> answer_s)
        else $error("apb answer not two cycles after setup");
    ready_in_access_a: assert property (pready |-> psel && penable && $past(psel))
        else $error("pready outside an access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    mapped_ok_a: assert property (pready && paddr <= CRTC_OFS_WAKE && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on a mapped register");
    rdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data moved outside a read answer");
    irq_masked_a: assert property (wr_s(CRTC_OFS_MASK, pwdata[2:0] == 3'h0) |-> ##[1:2] !irq)
        else $error("irq stays high with all enables off");
    wake_masked_a: assert property (wr_s(CRTC_OFS_WAKE, pwdata[2:0] == 3'h0) |-> ##[1:2] !wakeup)
        else $error("wakeup stays high with all enables off");
    cal_off_a: assert property (wr_s(CRTC_OFS_CTRL, !pwdata[CRTC_CTRL_CAL_BIT]) |-> ##[1:2] !cal_out)
        else $error("calibration output not stopped");
endmodule

bind crtc_core crtc_props u_props (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .wakeup(wakeup), .cal_out(cal_out)
);

// ---- testbench/test_calendar_rtc_core.sv ----
// self-checking bench of the calendar rtc core over apb
`timescale 1ns/1ps
module test_calendar_rtc_core;
    import crtc_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } crtc_row_t;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic por_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, wakeup, cal_out, er, c0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    // oscillator levels: slow, fast internal, fast external
    logic [2:0] osc = 3'h0, run = 3'h0;
    int err_count = 0, n_compared = 0, n;
    // register reads and writes: write, address, data, expected read, expected error
    crtc_row_t rows [15] = '{'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h7FFF, 1'b0},
        '{1'b0, 8'h08, 32'h0, 32'h01000000, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h101, 1'b0},
        '{1'b0, 8'h14, 32'h0, 32'h1, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h1C, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h20, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h24, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h24, 32'hFFFFFFFF, 32'h0, 1'b1},
        '{1'b0, 8'h24, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h14, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h14, 32'h0, 32'h1, 1'b0}, '{1'b1, 8'h04, 32'h3, 32'h0, 1'b0},
        '{1'b0, 8'h04, 32'h0, 32'h3, 1'b0}};
    // date word before and after a midnight wrap: leap, common, century
    logic [31:0] cal [3][2] = '{'{32'h0004021C, 32'h0004021D}, '{32'h0005021C, 32'h00050301},
        '{32'h00630C1F, 32'h00000101}};

    initial begin
        forever #5 pclk = ~pclk;
    end
    // a running source toggles each cycle, so it rises every second cycle
    always @(posedge pclk) osc <= osc ^ run;

    crtc_core dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_internal_rc_osc(osc[0]), .fast_internal_rc_osc(osc[1]),
        .fast_external_osc(osc[2]), .irq(irq), .wakeup(wakeup), .cal_out(cal_out));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, then an idle cycle so no signal is driven twice at one edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // bounded wait for the interrupt line, n holds the cycles spent
    task automatic wait_irq(input int max);
        n = 0;
        while (irq !== 1'b1 && n < max) begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic summarize;
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #500000;
        err_count++;
        summarize;
    end

    // main sequence; stop mode has no port, so only system reset is exercised
    initial begin
        repeat (2) @(posedge pclk);
        por_n <= 1'b1;
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[k]) begin
            apb(rows[k].w, rows[k].a, rows[k].d);
            chk({31'h0, er}, {31'h0, rows[k].e});
            if (!rows[k].w) chk(rd, rows[k].x);
        end
        apb(1'b1, CRTC_OFS_MASK, 32'h4);
        apb(1'b1, CRTC_OFS_CTRL, 32'h1);
        foreach (cal[k]) begin
            apb(1'b1, CRTC_OFS_TIME, 32'h07173B3B);
            apb(1'b1, CRTC_OFS_DATE, cal[k][0]);
            apb(1'b1, CRTC_OFS_PRESC, 32'h3);
            apb(1'b0, CRTC_OFS_STATUS, 32'h0);
            run <= 3'h1;
            wait_irq(100);
            run <= 3'h0;
            chk({31'h0, n inside {[8:12]}}, 32'h1);
            apb(1'b0, CRTC_OFS_TIME, 32'h0);
            chk(rd, 32'h01000000);
            apb(1'b0, CRTC_OFS_DATE, 32'h0);
            chk(rd, cal[k][1]);
            apb(1'b0, CRTC_OFS_STATUS, 32'h0);
            chk(rd & 32'h4, 32'h4);
            @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
        end
        // system reset in mid-run must leave the clock state alone
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CRTC_OFS_PRESC, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, CRTC_OFS_DATE, 32'h0);
        chk(rd, 32'h101);
        apb(1'b1, CRTC_OFS_ALARM, 32'h01000002);
        apb(1'b1, CRTC_OFS_MASK, 32'h1);
        apb(1'b1, CRTC_OFS_WAKE, 32'h1);
        run <= 3'h1;
        wait_irq(100);
        run <= 3'h0;
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, CRTC_OFS_TIME, 32'h0);
        chk(rd, 32'h01000002);
        apb(1'b1, CRTC_OFS_MASK, 32'h0);
        @(posedge pclk);
        chk({30'h0, wakeup, irq}, 32'h2);
        apb(1'b0, CRTC_OFS_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        @(posedge pclk);
        chk({31'h0, wakeup}, 32'h0);
        // periodic event from each fast source; the other source must not count
        apb(1'b1, CRTC_OFS_MASK, 32'h2);
        for (int s = 1; s < 3; s++) begin
            apb(1'b1, CRTC_OFS_CTRL, {29'h0, s[1:0], 1'b1});
            apb(1'b1, CRTC_OFS_PERIOD, 32'h1);
            apb(1'b0, CRTC_OFS_STATUS, 32'h0);
            run <= 3'h6 ^ (3'h1 << s);
            wait_irq(600);
            chk({31'h0, irq}, 32'h0);
            run <= 3'h1 << s;
            wait_irq(1200);
            apb(1'b0, CRTC_OFS_STATUS, 32'h0);
            @(posedge pclk);
            wait_irq(1200);
            chk({31'h0, n inside {[500:512]}}, 32'h1);
            run <= 3'h0;
            apb(1'b0, CRTC_OFS_STATUS, 32'h0);
        end
        // calibration output toggles every 64 drive cycles at the default reload
        apb(1'b1, CRTC_OFS_PRESC, 32'h7FFF);
        apb(1'b1, CRTC_OFS_CTRL, 32'h9);
        run <= 3'h1;
        n = 0;
        @(posedge pclk);
        c0 = cal_out;
        repeat (600) begin
            @(posedge pclk);
            if (cal_out !== c0) n++;
            c0 = cal_out;
        end
        chk(n, 32'h4);
        apb(1'b1, CRTC_OFS_CTRL, 32'h1);
        @(posedge pclk);
        chk({31'h0, cal_out}, 32'h0);
        summarize;
    end
endmodule
